// ===== design/cpu_state_pkg.sv
// Shared constants and carrier types for the CPU control-register block.
package cpu_state_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
    localparam logic [15:0] GPR_FIRST = 16'hFEE0;
    localparam logic [15:0] GPR_LAST = 16'hFEFF;
    localparam logic [15:0] PERIPH_FIRST = 16'hFF00;
    localparam logic [15:0] PERIPH_LAST = 16'hFFFF;
    localparam logic [15:0] RAM_FIRST = 16'hFB00;
    localparam logic [15:0] RAM_LAST = 16'hFEFF;
    localparam int GPR_BYTES = 32;
    localparam int BANK_REGS = 8;

    // ------------------------------------------------------------------
    // Flag word layout and reset values
    // ------------------------------------------------------------------
    localparam int FLAG_IE = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_BANK_SELECT_HIGH = 5;
    localparam int FLAG_AC = 4;
    localparam int FLAG_BANK_SELECT_LOW = 3;
    localparam int FLAG_ISP = 1;
    localparam int FLAG_CY = 0;
    localparam logic [7:0] FLAG_RESET = 8'h02;
    localparam logic [15:0] SP_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Bus register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_FETCH_PTR = 8'h00;
    localparam logic [7:0] OFS_FLAG_WORD = 8'h04;
    localparam logic [7:0] OFS_STACK_PTR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_SEQ, OP_BRANCH, OP_MASK_IRQ, OP_UNMASK_IRQ,
        OP_BANK_SWITCH, OP_ARITH, OP_LOGIC, OP_ROTATE, OP_BIT_CY,
        OP_IRQ_ACCEPT, OP_SW_BREAK, OP_RET_IRQ, OP_RET_BREAK, OP_SET_ISP
    } op_e;

    typedef enum logic [2:0] {
        S_VEC_LO, S_VEC_HI, S_RUN, S_PUSH, S_POP
    } seq_e;

    typedef enum logic [1:0] {W_BIT, W_BYTE, W_WORD} width_e;

    typedef struct packed {
        op_e kind;
        logic [2:0] len;
        logic [15:0] target;
        logic [1:0] bank;
        logic [7:0] a;
        logic [7:0] b;
        logic sub;
        logic bit_val;
    } cpu_op_s;

    typedef struct packed {
        logic valid;
        logic we;
        logic pair;
        logic by_name;
        logic [2:0] idx;
        logic [15:0] addr;
        logic [15:0] wdata;
    } gpr_req_s;

    typedef struct packed {
        logic valid;
        logic we;
        width_e width;
        logic [15:0] addr;
    } periph_req_s;

    typedef struct packed {
        logic rd_ok;
        logic wr_ok;
        logic bit_ok;
        logic byte_ok;
        logic word_ok;
    } periph_attr_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

endpackage

// ===== design/gpr_banks.sv
// Four banks of eight byte registers with byte and pair access.
`timescale 1ns/1ns
module gpr_banks (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Access request
    input wire cpu_state_pkg::gpr_req_s req,
    input wire logic [1:0] bank,
    // Answer
    output logic [15:0] rdata,
    output logic hit
);

    typedef struct packed {
        logic [15:0] rdata;
        logic hit;
    } gpr_state_s;

    gpr_state_s s_reg;
    gpr_state_s s_next;
    logic [7:0] mem [cpu_state_pkg::GPR_BYTES];
    logic [4:0] ofs;
    logic in_range;

    // Byte offset inside FEE0H..FEFFH; a pair always starts on an even byte.
    always_comb begin
        if (req.by_name) begin
            ofs = {bank, req.idx};
        end else begin
            ofs = req.addr[4:0];
        end
        if (req.pair) begin
            ofs[0] = 1'b0;
        end
        in_range = req.by_name ||
            (req.addr >= cpu_state_pkg::GPR_FIRST &&
             req.addr <= cpu_state_pkg::GPR_LAST);
    end

    always_comb begin
        s_next = s_reg;
        s_next.hit = req.valid && in_range;
        if (req.valid && in_range && !req.we) begin
            s_next.rdata = {req.pair ? mem[ofs + 5'h01] : 8'h00, mem[ofs]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Register contents live in RAM and have no reset value.
    always_ff @(posedge hclk) begin
        if (req.valid && in_range && req.we) begin
            mem[ofs] <= req.wdata[7:0];
            if (req.pair) begin
                mem[ofs + 5'h01] <= req.wdata[15:8];
            end
        end
    end

    assign rdata = s_reg.rdata;
    assign hit = s_reg.hit;

endmodule

// ===== design/periph_access_check.sv
// Access-width and direction check for the peripheral register area.
`timescale 1ns/1ns
module periph_access_check (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request and the addressed register's attributes
    input wire cpu_state_pkg::periph_req_s req,
    input wire cpu_state_pkg::periph_attr_s attr,
    // Verdict
    output logic allow,
    output logic fault
);

    typedef struct packed {
        logic allow;
        logic fault;
    } chk_state_s;

    chk_state_s s_reg;
    chk_state_s s_next;
    logic in_area;
    logic width_ok;
    logic dir_ok;

    always_comb begin
        in_area = req.addr >= cpu_state_pkg::PERIPH_FIRST &&
            req.addr <= cpu_state_pkg::PERIPH_LAST;
        unique case (req.width)
            cpu_state_pkg::W_BIT: width_ok = attr.bit_ok;
            cpu_state_pkg::W_BYTE: width_ok = attr.byte_ok;
            cpu_state_pkg::W_WORD: width_ok = attr.word_ok &&
                !req.addr[0];
            default: width_ok = 1'b0;
        endcase
        dir_ok = req.we ? attr.wr_ok : attr.rd_ok;
        s_next.allow = req.valid && in_area && width_ok && dir_ok;
        s_next.fault = req.valid && in_area && !(width_ok && dir_ok);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign allow = s_reg.allow;
    assign fault = s_reg.fault;

endmodule

// ===== design/cpu_state_regs.sv
// Program counter, flag word, stack pointer and their sequencing.
`timescale 1ns/1ns

module cpu_state_regs (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Operations from the instruction decoder
    input wire logic op_valid,
    input wire cpu_state_pkg::cpu_op_s op,
    // Maskable interrupt request from the interrupt controller
    input wire logic irq_req,
    input wire logic irq_low_prio,
    input wire logic irq_masked,
    output logic irq_grant,
    // Byte memory port for vectors and the stack
    output cpu_state_pkg::mem_req_s mem,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    // General registers
    input wire cpu_state_pkg::gpr_req_s gpr_req,
    output logic [15:0] gpr_rdata,
    output logic gpr_hit,
    // Peripheral access check
    input wire cpu_state_pkg::periph_req_s periph_req,
    input wire cpu_state_pkg::periph_attr_s periph_attr,
    output logic periph_allow,
    output logic periph_fault,
    // Architectural state
    output logic [15:0] fetch_ptr,
    output logic [7:0] flag_word,
    output logic [15:0] stack_ptr,
    output logic busy
);

    typedef struct packed {
        cpu_state_pkg::seq_e seq;
        logic [1:0] step;
        logic [15:0] pc;
        logic [7:0] cpu_flag_word;
        logic [15:0] sp;
        logic [15:0] vec_addr;
        logic [7:0] tmp_lo;
        logic vec_after;
        cpu_state_pkg::mem_req_s mem;
        logic irq_grant;
        logic sp_bad;
        logic busy;
        logic dph_wr;
        logic [7:0] dph_ofs;
        logic [31:0] hrdata;
        logic hreadyout;
    } state_s;

    // The stack pointer resets to 0000H, outside RAM; software loads it.
    localparam state_s STATE_RESET = '{
        seq: cpu_state_pkg::S_VEC_LO,
        step: 2'h0,
        pc: 16'h0000,
        cpu_flag_word: cpu_state_pkg::FLAG_RESET,
        sp: cpu_state_pkg::SP_RESET,
        vec_addr: cpu_state_pkg::RESET_VEC_ADDR,
        tmp_lo: 8'h00,
        vec_after: 1'b0,
        mem: '{req: 1'b1, we: 1'b0,
               addr: cpu_state_pkg::RESET_VEC_ADDR, wdata: 8'h00},
        irq_grant: 1'b0,
        sp_bad: 1'b1,
        busy: 1'b1,
        dph_wr: 1'b0,
        dph_ofs: 8'h00,
        hrdata: 32'h0000_0000,
        hreadyout: 1'b1
    };

    state_s s_reg;
    state_s s_next;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [7:0] result;
    logic addr_phase;

    // ------------------------------------------------------------------
    // Arithmetic flags
    // ------------------------------------------------------------------
    always_comb begin
        if (op.sub) begin
            sum9 = {1'b0, op.a} - {1'b0, op.b};
            sum_lo = {1'b0, op.a[3:0]} - {1'b0, op.b[3:0]};
        end else begin
            sum9 = {1'b0, op.a} + {1'b0, op.b};
            sum_lo = {1'b0, op.a[3:0]} + {1'b0, op.b[3:0]};
        end
        result = sum9[7:0];
        addr_phase = hsel && htrans[1] && hready;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.irq_grant = 1'b0;

        unique case (s_reg.seq)
            cpu_state_pkg::S_VEC_LO: begin
                if (mem_ack) begin
                    s_next.pc[7:0] = mem_rdata;
                    s_next.mem.addr = s_reg.vec_addr + 16'h0001;
                    s_next.seq = cpu_state_pkg::S_VEC_HI;
                end
            end
            cpu_state_pkg::S_VEC_HI: begin
                if (mem_ack) begin
                    s_next.pc[15:8] = mem_rdata;
                    s_next.mem.req = 1'b0;
                    s_next.seq = cpu_state_pkg::S_RUN;
                end
            end
            cpu_state_pkg::S_PUSH: begin
                if (mem_ack) begin
                    s_next.sp = s_reg.mem.addr;
                    s_next.step = s_reg.step + 2'h1;
                    s_next.mem.addr = s_reg.mem.addr - 16'h0001;
                    s_next.mem.wdata = (s_reg.step == 2'h0) ?
                        s_reg.pc[15:8] : s_reg.pc[7:0];
                    if (s_reg.step == 2'h2) begin
                        s_next.mem.we = 1'b0;
                        s_next.mem.addr = s_reg.vec_addr;
                        s_next.seq = cpu_state_pkg::S_VEC_LO;
                    end
                end
            end
            cpu_state_pkg::S_POP: begin
                if (mem_ack) begin
                    s_next.sp = s_reg.mem.addr + 16'h0001;
                    s_next.mem.addr = s_reg.mem.addr + 16'h0001;
                    s_next.step = s_reg.step + 2'h1;
                    if (s_reg.step == 2'h0) begin
                        s_next.tmp_lo = mem_rdata;
                    end else if (s_reg.step == 2'h1) begin
                        s_next.pc = {mem_rdata, s_reg.tmp_lo};
                    end else begin
                        s_next.cpu_flag_word = mem_rdata;
                        s_next.mem.req = 1'b0;
                        s_next.seq = cpu_state_pkg::S_RUN;
                    end
                end
            end
            cpu_state_pkg::S_RUN: begin
                if (op_valid) begin
                    unique case (op.kind)
                        cpu_state_pkg::OP_NONE: begin
                        end
                        cpu_state_pkg::OP_SEQ: begin
                            s_next.pc = s_reg.pc + {13'h0000, op.len};
                        end
                        cpu_state_pkg::OP_BRANCH: begin
                            s_next.pc = op.target;
                        end
                        cpu_state_pkg::OP_MASK_IRQ: begin
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_IE] = 1'b0;
                        end
                        cpu_state_pkg::OP_UNMASK_IRQ: begin
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_IE] = 1'b1;
                        end
                        cpu_state_pkg::OP_BANK_SWITCH: begin
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_BANK_SELECT_HIGH] =
                                op.bank[1];
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_BANK_SELECT_LOW] =
                                op.bank[0];
                        end
                        cpu_state_pkg::OP_ARITH: begin
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_Z] =
                                (result == 8'h00);
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_AC] =
                                sum_lo[4];
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_CY] =
                                sum9[8];
                        end
                        cpu_state_pkg::OP_LOGIC: begin
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_Z] =
                                (op.a == 8'h00);
                        end
                        cpu_state_pkg::OP_ROTATE,
                        cpu_state_pkg::OP_BIT_CY: begin
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_CY] =
                                op.bit_val;
                        end
                        cpu_state_pkg::OP_SET_ISP: begin
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_ISP] = op.bit_val;
                        end
                        cpu_state_pkg::OP_IRQ_ACCEPT,
                        cpu_state_pkg::OP_SW_BREAK: begin
                            // Flags go first, as they stood before the clear.
                            s_next.mem = '{req: 1'b1, we: 1'b1,
                                addr: s_reg.sp - 16'h0001,
                                wdata: s_reg.cpu_flag_word};
                            s_next.vec_addr = op.target;
                            s_next.step = 2'h0;
                            s_next.seq = cpu_state_pkg::S_PUSH;
                            s_next.cpu_flag_word[cpu_state_pkg::FLAG_IE] = 1'b0;
                        end
                        cpu_state_pkg::OP_RET_IRQ,
                        cpu_state_pkg::OP_RET_BREAK: begin
                            s_next.mem = '{req: 1'b1, we: 1'b0,
                                addr: s_reg.sp, wdata: 8'h00};
                            s_next.step = 2'h0;
                            s_next.seq = cpu_state_pkg::S_POP;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                s_next.seq = cpu_state_pkg::S_RUN;
            end
        endcase

        // Grant is withheld while an operation or stack sequence is pending.
        s_next.irq_grant = irq_req && !irq_masked &&
            s_reg.cpu_flag_word[cpu_state_pkg::FLAG_IE] &&
            !(irq_low_prio && !s_reg.cpu_flag_word[cpu_state_pkg::FLAG_ISP]) &&
            s_reg.seq == cpu_state_pkg::S_RUN && !op_valid;

        // Bus writes land last so software has the final say on a clash.
        if (s_reg.dph_wr) begin
            if (s_reg.dph_ofs == cpu_state_pkg::OFS_FLAG_WORD) begin
                s_next.cpu_flag_word = hwdata[7:0];
            end
            if (s_reg.dph_ofs == cpu_state_pkg::OFS_STACK_PTR) begin
                s_next.sp = hwdata[15:0];
            end
        end

        s_next.sp_bad = s_next.sp < cpu_state_pkg::RAM_FIRST ||
            s_next.sp > cpu_state_pkg::RAM_LAST;
        s_next.busy = s_next.seq != cpu_state_pkg::S_RUN;

        // ------------------------------------------------------------------
        // AHB-Lite slave, zero wait states, always OKAY
        // ------------------------------------------------------------------
        s_next.dph_wr = addr_phase && hwrite;
        s_next.dph_ofs = haddr[7:0];
        s_next.hrdata = 32'h0000_0000;
        if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                cpu_state_pkg::OFS_FETCH_PTR:
                    s_next.hrdata = {16'h0000, s_reg.pc};
                cpu_state_pkg::OFS_FLAG_WORD:
                    s_next.hrdata = {24'h000000, s_reg.cpu_flag_word};
                cpu_state_pkg::OFS_STACK_PTR:
                    s_next.hrdata = {16'h0000, s_reg.sp};
                cpu_state_pkg::OFS_STATUS:
                    s_next.hrdata = {26'h0000000, s_reg.sp_bad,
                        s_reg.busy, 1'b0, s_reg.seq};
                default:
                    s_next.hrdata = 32'h0000_0000;
            endcase
        end
        s_next.hreadyout = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Register banks and peripheral access check
    // ------------------------------------------------------------------
    gpr_banks u_gpr_banks (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(gpr_req),
        .bank({s_reg.cpu_flag_word[cpu_state_pkg::FLAG_BANK_SELECT_HIGH],
               s_reg.cpu_flag_word[cpu_state_pkg::FLAG_BANK_SELECT_LOW]}),
        .rdata(gpr_rdata),
        .hit(gpr_hit)
    );

    periph_access_check u_periph_access_check (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(periph_req),
        .attr(periph_attr),
        .allow(periph_allow),
        .fault(periph_fault)
    );

    assign hrdata = s_reg.hrdata;
    assign hreadyout = s_reg.hreadyout;
    assign hresp = 1'b0;
    assign irq_grant = s_reg.irq_grant;
    assign mem = s_reg.mem;
    assign fetch_ptr = s_reg.pc;
    assign flag_word = s_reg.cpu_flag_word;
    assign stack_ptr = s_reg.sp;
    assign busy = s_reg.busy;

endmodule

// ===== tb/cpu_state_regs_props.sv
// Concurrent checks on the CPU control-register block.
`timescale 1ns/1ns
module cpu_state_regs_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Watched ports
    input wire logic op_valid,
    input wire cpu_state_pkg::cpu_op_s op,
    input wire logic irq_req,
    input wire logic irq_low_prio,
    input wire logic irq_masked,
    input wire logic irq_grant,
    input wire cpu_state_pkg::mem_req_s mem,
    input wire logic [15:0] fetch_ptr,
    input wire logic [7:0] flag_word,
    input wire logic [15:0] stack_ptr,
    input wire logic busy
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic go;
    assign go = op_valid && !busy;
    AST_SEQ: assert property (go && op.kind == cpu_state_pkg::OP_SEQ |=>
        fetch_ptr == $past(fetch_ptr) + 16'($past(op.len)))
        else $error("pointer not advanced");
    AST_BRANCH: assert property (
        go && op.kind == cpu_state_pkg::OP_BRANCH
        |=> fetch_ptr == $past(op.target)) else $error("branch not taken");
    AST_MASK: assert property (
        go && op.kind == cpu_state_pkg::OP_MASK_IRQ
        |=> !flag_word[7]) else $error("enable not cleared");
    AST_UNMASK: assert property (
        go && op.kind == cpu_state_pkg::OP_UNMASK_IRQ
        |=> flag_word[7]) else $error("enable not set");
    AST_BANK: assert property (
        go && op.kind == cpu_state_pkg::OP_BANK_SWITCH
        |=> {flag_word[5], flag_word[3]} == $past(op.bank))
        else $error("bank bits wrong");
    AST_ZERO: assert property (
        go && op.kind == cpu_state_pkg::OP_LOGIC |=>
        flag_word[6] == ($past(op.a) == 8'h00)) else $error("zero flag wrong");
    AST_GRANT_IE: assert property (irq_grant |->
        $past(flag_word[7] && irq_req && !irq_masked))
        else $error("grant without enable");
    AST_GRANT_PRIO: assert property (irq_grant |->
        !$past(irq_low_prio && !flag_word[1])) else $error("low granted");
    AST_PUSH: assert property (mem.req && mem.we |->
        mem.addr == stack_ptr - 16'h0001) else $error("push address wrong");
    COV_SEQ: cover property (go && op.kind == cpu_state_pkg::OP_SEQ);
    COV_GRANT: cover property (irq_grant);
    COV_PUSH: cover property (mem.req && mem.we);
endmodule

bind cpu_state_regs cpu_state_regs_props i_props (.hclk(hclk),
    .hresetn(hresetn), .op_valid(op_valid), .op(op), .irq_req(irq_req),
    .irq_low_prio(irq_low_prio), .irq_masked(irq_masked),
    .irq_grant(irq_grant), .mem(mem), .fetch_ptr(fetch_ptr),
    .flag_word(flag_word), .stack_ptr(stack_ptr), .busy(busy));

// ===== tb/cpu_state_regs_tb_top.sv
// Self-checking bench for the CPU control-register block.
`timescale 1ns/1ns
module cpu_state_regs_tb_top;
    logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, op_valid = '0;
    logic irq_req = '0, irq_low_prio = '0, irq_masked = '0, mem_ack = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [7:0] mem_rdata = '0, flag_word;
    logic hreadyout, hresp, irq_grant, busy, g, gh, pal, pfl;
    logic [15:0] fetch_ptr, stack_ptr, e, gd;
    cpu_state_pkg::cpu_op_s op = '0;
    cpu_state_pkg::gpr_req_s gq = '0;
    cpu_state_pkg::periph_req_s pq = '0;
    cpu_state_pkg::periph_attr_s pa = '0;
    cpu_state_pkg::mem_req_s mem;
    logic [7:0] ram [logic [15:0]];
    int err_count = 0, num_checks = 0, cyc = 0;

    cpu_state_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .op_valid(op_valid), .op(op),
        .irq_req(irq_req), .irq_low_prio(irq_low_prio),
        .irq_masked(irq_masked), .irq_grant(irq_grant), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .gpr_req(gq),
        .gpr_rdata(gd), .gpr_hit(gh), .periph_req(pq), .periph_attr(pa),
        .periph_allow(pal), .periph_fault(pfl), .fetch_ptr(fetch_ptr),
        .flag_word(flag_word), .stack_ptr(stack_ptr), .busy(busy));

    initial forever #2 hclk = ~hclk;

    // Byte memory answers every held request after one cycle.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
        mem_ack <= hresetn && mem.req && !mem_ack;
        if (hresetn && mem.req && !mem_ack) begin
            mem_rdata <= ram.exists(mem.addr) ? ram[mem.addr] : 8'hA5;
            if (mem.we) ram[mem.addr] = mem.wdata;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    task automatic do_op(input cpu_state_pkg::op_e k, input logic [15:0] t,
        input logic [7:0] a, b, input logic s);
        @(posedge hclk);
        op_valid <= 1'h1;
        op <= '{k, t[2:0], t, t[1:0], a, b, s, s};
        @(posedge hclk);
        op_valid <= 1'h0;
        repeat (2) @(posedge hclk);
        while (busy !== 1'h0) @(posedge hclk);
    endtask

    task automatic watch(input int n);
        g = 1'h0;
        repeat (n) @(posedge hclk) g = g | irq_grant;
    endtask

    task automatic t_reset;
        while (busy !== 1'h0) @(posedge hclk);
        chk(fetch_ptr, 16'h1234);
        chk(flag_word, cpu_state_pkg::FLAG_RESET);
        ahb(1'h0, 32'hC, 32'h0);
        chk(rd, 32'h22);
        chk(hresp, 1'h0);
        ahb(1'h1, 32'h8, 32'hFEE0);
        ahb(1'h0, 32'h8, 32'h0);
        chk(rd, 32'hFEE0);
        ahb(1'h1, 32'h0, 32'h0);
        ahb(1'h0, 32'h0, 32'h0);
        chk(rd, 32'h1234);
        ahb(1'h0, 32'h40, 32'h0);
        chk(rd, 32'h0);
        $display("done: reset and bus");
    endtask

    task automatic t_pc;
        e = 16'h1234;
        for (int n = 1; n < 5; n++) begin
            e = e + 16'(n);
            do_op(cpu_state_pkg::OP_SEQ, 16'(n), '0, '0, '0);
            chk(fetch_ptr, e);
        end
        do_op(cpu_state_pkg::OP_BRANCH, 16'h2ABC, '0, '0, '0);
        chk(fetch_ptr, 16'h2ABC);
        $display("done: fetch pointer");
    endtask

    task automatic t_flags;
        logic [7:0] av [5] = '{8'h0F, 8'hFF, 8'h10, 8'h00, 8'h22};
        logic [7:0] bv [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h11};
        logic [4:0] sv = 5'h0C;
        logic [8:0] r;
        logic h;
        for (int i = 0; i < 5; i++) begin
            r = sv[i] ? {1'h0, av[i]} - {1'h0, bv[i]}
                : {1'h0, av[i]} + {1'h0, bv[i]};
            h = sv[i] ? av[i][3:0] < bv[i][3:0]
                : {1'h0, av[i][3:0]} + {1'h0, bv[i][3:0]} > 5'h0F;
            do_op(cpu_state_pkg::OP_ARITH, '0, av[i], bv[i], sv[i]);
            chk({flag_word[6], flag_word[4], flag_word[0]},
                {r[7:0] == 8'h00, h, r[8]});
        end
        for (int b = 0; b < 4; b++) begin
            do_op(cpu_state_pkg::OP_BANK_SWITCH, 16'(b), '0, '0, '0);
            chk({flag_word[5], flag_word[3]}, b[1:0]);
        end
        do_op(cpu_state_pkg::OP_LOGIC, '0, 8'h00, '0, '0);
        chk(flag_word[6], 1'h1);
        do_op(cpu_state_pkg::OP_ROTATE, '0, '0, '0, 1'h1);
        chk(flag_word[0], 1'h1);
        do_op(cpu_state_pkg::OP_BIT_CY, '0, '0, '0, 1'h0);
        chk(flag_word[0], 1'h0);
        $display("done: flags");
    endtask

    task automatic t_irq;
        do_op(cpu_state_pkg::OP_SET_ISP, '0, '0, '0, 1'h0);
        do_op(cpu_state_pkg::OP_UNMASK_IRQ, '0, '0, '0, '0);
        irq_low_prio <= 1'h1;
        irq_req <= 1'h1;
        watch(8);
        chk(g, 1'h0);
        irq_low_prio <= 1'h0;
        watch(8);
        chk(g, 1'h1);
        do_op(cpu_state_pkg::OP_MASK_IRQ, '0, '0, '0, '0);
        watch(8);
        chk(g, 1'h0);
        irq_req <= 1'h0;
        ram[16'h0006] = 8'h78;
        ram[16'h0007] = 8'h56;
        for (int i = 0; i < 2; i++) begin
            ahb(1'h1, 32'h4, 32'hA1);
            do_op(i ? cpu_state_pkg::OP_SW_BREAK
                : cpu_state_pkg::OP_IRQ_ACCEPT, 16'h0006, '0, '0, '0);
            chk(stack_ptr, 16'hFEDD);
            chk({ram[16'hFEDF], ram[16'hFEDE], ram[16'hFEDD]},
                24'hA12ABC);
            chk({flag_word[7], fetch_ptr}, 17'h05678);
            do_op(i ? cpu_state_pkg::OP_RET_BREAK : cpu_state_pkg::OP_RET_IRQ,
                '0, '0, '0, '0);
            chk({stack_ptr, fetch_ptr}, 32'hFEE02ABC);
            chk(flag_word, 8'hA1);
        end
        $display("done: interrupt and break");
    endtask

    task automatic t_regs;
        pa <= '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1};
        for (int i = 0; i < 4; i++) begin
            gq <= '{1'h1, i == 0, i < 2, i == 0, 3'h2,
                i < 2 ? 16'hFEF2 : 16'hFD00, 16'hBEEF};
            pq <= '{1'h1, i > 1, cpu_state_pkg::W_WORD,
                {7'h7F, i != 3, 7'h08, i == 1}};
            repeat (2) @(posedge hclk);
            chk({gh, gd}, {i < 2, i ? 16'hBEEF : 16'h0});
            chk({pal, pfl}, {i == 0, i == 1 || i == 2});
        end
        $display("done: banks and access");
    endtask

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        ram[16'h0000] = 8'h34;
        ram[16'h0001] = 8'h12;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        t_reset();
        t_pc();
        t_flags();
        t_irq();
        t_regs();
        end_sim();
    end
endmodule
